// ### logic/hvp_scaler.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hvp_map.svh"
// Functional notes
// RULE_01 - scale equals 1/ratio times 1024/phase
// RULE_02 - prescale ratio kept within 1 to 63
// RULE_03 - phase parameter kept within 300 to 8191
// RULE_04 - fine scaler interpolates with 6-bit phase
// RULE_05 - averaging length is field plus one
// RULE_06 - weight bit doubles inner accumulated pixels
// RULE_07 - dc gain follows length and weighting
// RULE_08 - result shifted right by gain field
// RULE_09 - software keeps overall prescaler gain at most one
// RULE_10 - averaging field below twice prescale ratio
// RULE_11 - up to 64 averaging plus 7 taps
// RULE_12 - prefilter codes select bypass or kernels
// RULE_13 - shared timing, separate luma/chroma prefilters
// RULE_14 - raw source copy at line start/end
// RULE_15 - fine scaler from 1024/300 (about 3.4x) down to 1024/8191
// RULE_16 - one prescaled sample per ratio inputs
// RULE_17 - phase accumulates, top 6 fraction bits used
module hvp_scaler #(
    parameter int ACC_W = 16,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_sys_in,
    input  wire logic             nrst_in,
    input  wire hvp_pkg::hvp_pix_t src_y_in,
    input  wire hvp_pkg::hvp_pix_t src_c_in,
    input  wire logic             src_sol_in,
    input  wire logic             src_eol_in,
    input  wire logic             src_valid_in,
    output logic                  src_ready_out,
    output hvp_pkg::hvp_pix_t     dst_y_out,
    output hvp_pkg::hvp_pix_t     dst_c_out,
    output logic                  dst_sol_out,
    output logic                  dst_eol_out,
    output logic                  dst_valid_out,
    input  wire logic             dst_ready_in,
    hvp_if.dev                    link
);
    import hvp_pkg::*;
    localparam int PIX_W = $bits(hvp_pix_t);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int BUF_W = 2 * PIX_W + 2;
    // ****************************************
    // register file
    // ****************************************
    logic [5:0]  ratio;
    logic [5:0]  acl;
    logic [7:0]  ctl;
    logic [12:0] inc;
    logic        have;
    logic        pre_v;
    logic [PTR_W:0] cnt_b;
    wire  [2:0] gain = ctl[`HVP_CTL_GAIN_LSB +: 3];
    wire        dbl  = ctl[`HVP_CTL_WEIGHT];
    wire  [1:0] luma_prefilter_select  = ctl[`HVP_CTL_PFY_LSB +: 2];
    wire  [1:0] chroma_prefilter_select = ctl[`HVP_CTL_CHROMA_PREFILTER_SELECT_LSB +: 2];
    wire        full = (cnt_b == (PTR_W + 1)'(DEPTH));
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ratio <= `HVP_RST_RATIO;
            acl   <= `HVP_RST_ACL;
            ctl   <= `HVP_RST_CTL;
            inc   <= `HVP_RST_PHASE;
        end else if (link.reg_we) begin
            case (link.reg_addr)
                `HVP_IDX_RATIO: ratio <= link.reg_wdata[5:0];
                `HVP_IDX_ACL:   acl <= link.reg_wdata[5:0];
                `HVP_IDX_CTL:   ctl <= link.reg_wdata;
                `HVP_IDX_PHL:   inc[7:0] <= link.reg_wdata;
                `HVP_IDX_PHH:   inc[12:8] <= link.reg_wdata[4:0];
                default: ;
            endcase
        end
    end
    assign link.reg_rdata = (link.reg_addr == `HVP_IDX_RATIO) ? {2'h0, ratio} :
                            (link.reg_addr == `HVP_IDX_ACL)   ? {2'h0, acl} :
                            (link.reg_addr == `HVP_IDX_CTL)   ? ctl :
                            (link.reg_addr == `HVP_IDX_PHL)   ? inc[7:0] :
                            (link.reg_addr == `HVP_IDX_PHH)   ? {3'h0, inc[12:8]} :
                            (link.reg_addr == `HVP_IDX_STAT)  ? {5'h0, have, pre_v, full} : 8'h00;
    // ****************************************
    // fir prefilter, window 0 is the newest sample
    // ****************************************
    function automatic hvp_pix_t prefilt(input logic [6:0][PIX_W-1:0] w, input logic [1:0] sel,
                                         input logic luma);
        int s;
        int r;
        s = int'(w[3]);
        r = 0;
        case (sel)
            2'h1: s = (int'(w[2]) + 2 * int'(w[3]) + int'(w[4])) >>> 2;
            2'h2: begin
                if (luma) begin
                    s = (-4 * int'(w[0]) + 4 * int'(w[1]) + 7 * int'(w[2]) + 18 * int'(w[3])
                         + 7 * int'(w[4]) + 4 * int'(w[5]) - 4 * int'(w[6])) >>> 5;
                end else begin
                    s = (3 * int'(w[1]) + 8 * int'(w[2]) + 10 * int'(w[3]) + 8 * int'(w[4])
                         + 3 * int'(w[5])) >>> 5;
                end
            end
            2'h3: s = (int'(w[1]) + 2 * int'(w[2]) + 2 * int'(w[3]) + 2 * int'(w[4])
                       + int'(w[5])) >>> 3;
            default: s = int'(w[3]);
        endcase
        r = (s < 0) ? 0 : ((s > (1 << PIX_W) - 1) ? (1 << PIX_W) - 1 : s);
        return PIX_W'(r);
    endfunction
    logic [6:0][PIX_W-1:0] wy;
    logic [6:0][PIX_W-1:0] wc;
    logic [6:0][PIX_W-1:0] next_wy;
    logic [6:0][PIX_W-1:0] next_wc;
    // a line start fills the window with its own sample so no old line leaks in
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            next_wy[i] = (src_sol_in || i == 0) ? src_y_in : wy[(i > 0) ? i - 1 : 0];
            next_wc[i] = (src_sol_in || i == 0) ? src_c_in : wc[(i > 0) ? i - 1 : 0];
        end
    end
    wire hvp_pix_t fy = prefilt(next_wy, luma_prefilter_select, 1'b1);                              // RULE_12 RULE_13
    wire hvp_pix_t fc = prefilt(next_wc, chroma_prefilter_select, 1'b0);                             // RULE_12 RULE_13
    // ****************************************
    // integer prescaler, two accumulators so a run may span two periods
    // ****************************************
    logic [5:0]       cnt;
    logic             sel;
    logic [1:0]       act;
    logic [1:0][5:0]  k;
    logic [1:0][ACC_W-1:0] sy;
    logic [1:0][ACC_W-1:0] sc;
    logic [1:0][ACC_W-1:0] ny;
    logic [1:0][ACC_W-1:0] nc;
    logic [1:0]       st;
    logic [1:0]       on;
    logic [1:0]       done;
    logic [1:0][5:0]  tk;
    wire        in_fire = src_valid_in && src_ready_out;
    wire  [5:0] cur_cnt = src_sol_in ? 6'h00 : cnt;
    wire        start   = (cur_cnt == 6'h00);                                     // RULE_16
    wire        sel_eff = src_sol_in ? 1'b0 : sel;
    always_comb begin
        for (int a = 0; a < 2; a++) begin
            st[a]   = start && (sel_eff == a[0]);
            on[a]   = st[a] || (act[a] && !src_sol_in);
            tk[a]   = st[a] ? 6'h00 : k[a];
            done[a] = on[a] && (tk[a] == acl);                                    // RULE_05 RULE_11
            // inner taps weigh two when doubling is on
            ny[a] = (st[a] ? '0 : sy[a])
                    + (ACC_W'(fy) << ((tk[a] != 6'h00 && tk[a] != acl && dbl) ? 1 : 0)); // RULE_06 RULE_07
            nc[a] = (st[a] ? '0 : sc[a])
                    + (ACC_W'(fc) << ((tk[a] != 6'h00 && tk[a] != acl && dbl) ? 1 : 0));
        end
    end
    wire [ACC_W-1:0] shy  = (done[0] ? ny[0] : ny[1]) >> gain;                    // RULE_08
    wire [ACC_W-1:0] shc  = (done[0] ? nc[0] : nc[1]) >> gain;
    wire hvp_pix_t   avy  = (shy > ACC_W'((1 << PIX_W) - 1)) ? '1 : shy[PIX_W-1:0];
    wire hvp_pix_t   avc  = (shc > ACC_W'((1 << PIX_W) - 1)) ? '1 : shc[PIX_W-1:0];
    wire             edge_l = src_sol_in || src_eol_in;
    wire             emit = edge_l || (|done);
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wy  <= '0;
            wc  <= '0;
            cnt <= 6'h00;
            sel <= 1'b0;
            act <= 2'b00;
            k   <= '0;
            sy  <= '0;
            sc  <= '0;
        end else if (in_fire) begin
            wy  <= next_wy;
            wc  <= next_wc;
            cnt <= (cur_cnt >= ratio - 6'h01) ? 6'h00 : cur_cnt + 6'h01;         // RULE_16
            sel <= start ? ~sel_eff : sel_eff;
            for (int a = 0; a < 2; a++) begin
                act[a] <= on[a] && !done[a];
                k[a]   <= tk[a] + 6'h01;
                sy[a]  <= ny[a];
                sc[a]  <= nc[a];
            end
        end
    end
    // ****************************************
    // prescaled sample holding register
    // ****************************************
    hvp_pix_t pre_y;
    hvp_pix_t pre_c;
    logic     pre_sol;
    logic     pre_eol;
    logic     consume;
    // one sample of slack only; the fine scaler stalls the source while it works
    assign src_ready_out = !pre_v;
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_v   <= 1'b0;
            pre_y   <= '0;
            pre_c   <= '0;
            pre_sol <= 1'b0;
            pre_eol <= 1'b0;
        end else if (in_fire && emit) begin
            pre_v   <= 1'b1;
            pre_y   <= edge_l ? src_y_in : avy;                                   // RULE_14
            pre_c   <= edge_l ? src_c_in : avc;                                   // RULE_14
            pre_sol <= src_sol_in;
            pre_eol <= src_eol_in;
        end else if (consume) begin
            pre_v <= 1'b0;
        end
    end
    // ****************************************
    // fine scaler, phase in 1/1024 steps
    // ****************************************
    logic [13:0] ph;
    hvp_pix_t    prev_y;
    hvp_pix_t    prev_c;
    hvp_pix_t    cur_y;
    hvp_pix_t    cur_c;
    logic        cur_eol;
    logic        sol_pend;
    wire  [13:0] next_ph = 14'(ph + {1'b0, inc});                                 // RULE_15 RULE_17
    wire  [5:0]  frac    = ph[`HVP_FRAC_W-1 -: `HVP_INTERP_W];                     // RULE_04 RULE_17
    wire         at_end  = (ph >= `HVP_PHASE_ONE);
    // a line's tail ends on its last sample when the phase lands on it, else on the output before the phase would overshoot it
    wire         last    = cur_eol && (at_end || (next_ph > `HVP_PHASE_ONE));         // RULE_14
    // while a line's last sample is held nothing new enters, so the tail is never cut
    assign consume = pre_v && (!have || (!cur_eol && (pre_sol || at_end)));
    wire         produce = have && !consume && (!at_end || cur_eol) && !full;
    function automatic hvp_pix_t lerp(input hvp_pix_t a, input hvp_pix_t b, input logic [5:0] f);
        int r;
        r = (int'(a) * ((1 << `HVP_INTERP_W) - int'(f)) + int'(b) * int'(f)) >>> `HVP_INTERP_W;
        return PIX_W'(r);
    endfunction
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ph       <= 14'h0000;
            have     <= 1'b0;
            prev_y   <= '0;
            prev_c   <= '0;
            cur_y    <= '0;
            cur_c    <= '0;
            cur_eol  <= 1'b0;
            sol_pend <= 1'b0;
        end else if (consume && pre_sol) begin
            have     <= 1'b1;
            // one step back, so the first output lands on the first sample, not before it
            ph       <= `HVP_PHASE_ONE;
            prev_y   <= pre_y;
            prev_c   <= pre_c;
            cur_y    <= pre_y;
            cur_c    <= pre_c;
            cur_eol  <= pre_eol;
            sol_pend <= 1'b1;
        end else if (consume && have) begin
            ph      <= ph - `HVP_PHASE_ONE;                                       // RULE_01
            prev_y  <= cur_y;
            prev_c  <= cur_c;
            cur_y   <= pre_y;
            cur_c   <= pre_c;
            cur_eol <= pre_eol;
        end else if (produce) begin
            ph       <= next_ph;                                                  // RULE_17
            sol_pend <= 1'b0;
            if (last) begin
                have <= 1'b0;
            end
        end
    end
    // ****************************************
    // output buffer; a downstream stall backs up into the fine scaler
    // ****************************************
    logic [DEPTH-1:0][BUF_W-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    wire              pop = dst_valid_out && dst_ready_in;
    wire [BUF_W-1:0]  push_word = at_end ? {cur_y, cur_c, sol_pend, last} :
                                  {lerp(prev_y, cur_y, frac), lerp(prev_c, cur_c, frac),
                                   sol_pend, last};                               // RULE_04
    assign dst_valid_out = (cnt_b != '0);
    assign {dst_y_out, dst_c_out, dst_sol_out, dst_eol_out} = mem[rp];
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem   <= '0;
            wp    <= '0;
            rp    <= '0;
            cnt_b <= '0;
        end else begin
            if (produce) begin
                mem[wp] <= push_word;
                wp      <= (wp == PTR_W'(DEPTH - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == PTR_W'(DEPTH - 1)) ? '0 : rp + 1'b1;
            end
            cnt_b <= cnt_b + (PTR_W + 1)'(produce) - (PTR_W + 1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### logic/hvp_map.svh
`ifndef HVP_MAP_SVH
`define HVP_MAP_SVH
// ****************************************
// register indices on the device port
// ****************************************
`define HVP_IDX_RATIO    8'ha0
`define HVP_IDX_ACL      8'ha1
`define HVP_IDX_CTL      8'ha2
`define HVP_IDX_PHL      8'ha8
`define HVP_IDX_PHH      8'ha9
`define HVP_IDX_STAT     8'hab
// ****************************************
// field positions of the control register
// ****************************************
`define HVP_CTL_GAIN_LSB 0
`define HVP_CTL_WEIGHT   3
`define HVP_CTL_PFY_LSB  4
`define HVP_CTL_CHROMA_PREFILTER_SELECT_LSB 6
// ****************************************
// reset values
// ****************************************
`define HVP_RST_RATIO    6'h01
`define HVP_RST_ACL      6'h00
`define HVP_RST_CTL      8'h00
`define HVP_RST_PHASE    13'h0400
// ****************************************
// phase arithmetic
// ****************************************
`define HVP_PHASE_ONE    14'h0400
`define HVP_PHASE_MIN    13'h012c
`define HVP_FRAC_W       10
`define HVP_INTERP_W     6
`define HVP_RATIO_MIN    6'h01
`endif

// ### logic/hvp_pkg.sv
`default_nettype none
package hvp_pkg;
    typedef logic [7:0] hvp_pix_t;
    typedef enum {AH_IDLE, AH_WR, AH_WR2, AH_RD, AH_DONE} hvp_ahb_state_t;
endpackage
`default_nettype wire

// ### logic/hvp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hvp_if;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_we;
    logic [7:0] reg_rdata;
    modport dev  (input reg_addr, input reg_wdata, input reg_we, output reg_rdata);
    modport ctrl (output reg_addr, output reg_wdata, output reg_we, input reg_rdata);
endinterface
`default_nettype wire

// ### logic/hvp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "hvp_map.svh"
module hvp_ctrl (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    hvp_if.ctrl              link
);
    import hvp_pkg::*;
    // ****************************************
    // ahb-lite slave, one word per device register, except one word for both phase bytes
    // ****************************************
    hvp_ahb_state_t state;
    hvp_ahb_state_t next_state;
    logic [7:0]     idx;
    logic           wr_map;
    logic [5:0]     ratio_sh;
    logic [12:0]    phase_sh;
    wire  [7:0]  idx_in   = haddr_in[9:2];
    wire         take     = hsel_in && htrans_in[1] && hready_in && hreadyout_out;
    wire         mapped   = (idx_in == `HVP_IDX_RATIO) || (idx_in == `HVP_IDX_ACL) ||
                            (idx_in == `HVP_IDX_CTL) || (idx_in == `HVP_IDX_PHL);
    wire         ph_wr    = (state == AH_WR) && wr_map && (idx == `HVP_IDX_PHL);
    // ****************************************
    // write clamps keep the device in its legal range
    // ****************************************
    wire  [5:0]  w6       = hwdata_in[5:0];
    wire  [5:0]  ratio_w  = (w6 == 6'h00) ? `HVP_RATIO_MIN : w6;                  // RULE_02
    wire  [6:0]  acl_lim  = 7'({ratio_sh, 1'b0} - 7'h01);
    wire  [5:0]  acl_w    = ({1'b0, w6} > acl_lim) ? acl_lim[5:0] : w6;           // RULE_10
    wire  [12:0] ph_w     = (hwdata_in[12:0] < `HVP_PHASE_MIN) ? `HVP_PHASE_MIN
                                                                : hwdata_in[12:0]; // RULE_03
    // gain and weighting pass unchanged; a non power-of-two gain is software's to trim
    wire  [7:0]  ctl_w    = hwdata_in[7:0];                                        // RULE_09
    assign hreadyout_out  = (state != AH_RD) && !ph_wr;
    assign hresp_out      = 1'b0;
    assign link.reg_we    = ((state == AH_WR) || (state == AH_WR2)) && wr_map;
    assign link.reg_addr  = (state == AH_WR2) ? `HVP_IDX_PHH : idx;
    // the phase word reaches the device as two byte writes, low byte first
    assign link.reg_wdata = (state == AH_WR2)          ? {3'h0, ph_w[12:8]} :     // RULE_01
                            (idx == `HVP_IDX_PHL)      ? ph_w[7:0] :
                            (idx == `HVP_IDX_RATIO)    ? {2'h0, ratio_w} :
                            (idx == `HVP_IDX_ACL)      ? {2'h0, acl_w} : ctl_w;
    always_comb begin
        next_state = take ? (hwrite_in ? AH_WR : AH_RD) : AH_IDLE;
        case (state)
            AH_RD:   next_state = AH_DONE;
            AH_WR:   next_state = ph_wr ? AH_WR2 : next_state;
            default: ;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state  <= AH_IDLE;
            idx    <= 8'h00;
            wr_map <= 1'b0;
        end else begin
            state <= next_state;
            if (take) begin
                idx    <= idx_in;
                wr_map <= hwrite_in && mapped;
            end
        end
    end
    // ****************************************
    // shadows for clamping and the phase read-back
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ratio_sh <= `HVP_RST_RATIO;
            phase_sh <= `HVP_RST_PHASE;
        end else if ((state == AH_WR) && wr_map) begin
            if (idx == `HVP_IDX_RATIO) begin
                ratio_sh <= ratio_w;
            end
            if (idx == `HVP_IDX_PHL) begin
                phase_sh <= ph_w;
            end
        end
    end
    // ****************************************
    // read data is caught in the wait cycle
    // ****************************************
    wire rd_known = (idx == `HVP_IDX_RATIO) || (idx == `HVP_IDX_ACL) ||
                    (idx == `HVP_IDX_CTL) || (idx == `HVP_IDX_STAT);
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hrdata_out <= 32'h0;
        end else if (state == AH_RD) begin
            hrdata_out <= (idx == `HVP_IDX_PHL) ? {19'h0, phase_sh} :
                          rd_known ? {24'h0, link.reg_rdata} : 32'h0;
        end
    end
endmodule
`default_nettype wire

// ### dv/hvp_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
module hvp_link_checker (
    input wire logic       clk_sys_in,
    input wire logic       nrst_in,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we,
    input wire logic [7:0] reg_rdata
);
    // ****************************************
    // shadow of what the controller last wrote
    // ****************************************
    logic [5:0] ratio_q;
    logic [5:0] acl_q;
    logic [7:0] ctl_q;
    logic [7:0] lo_q;
    wire logic        w_ratio   = reg_we && reg_addr == 8'ha0;
    wire logic        w_acl     = reg_we && reg_addr == 8'ha1;
    wire logic        w_ctl     = reg_we && reg_addr == 8'ha2;
    wire logic        w_lo      = reg_we && reg_addr == 8'ha8;
    wire logic        w_hi      = reg_we && reg_addr == 8'ha9;
    wire logic [12:0] phase_new = {reg_wdata[4:0], lo_q};
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ratio_q <= 6'h01;
            acl_q   <= 6'h00;
            ctl_q   <= 8'h00;
            lo_q    <= 8'h00;
        end else begin
            if (w_ratio) ratio_q <= reg_wdata[5:0];
            if (w_acl) acl_q <= reg_wdata[5:0];
            if (w_ctl) ctl_q <= reg_wdata;
            if (w_lo) lo_q <= reg_wdata;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    property p_ratio_nz;
        w_ratio |-> reg_wdata[5:0] != 6'h00;
    endproperty
    property p_ratio_rd;
        reg_addr == 8'ha0 |-> reg_rdata[5:0] == ratio_q;
    endproperty
    property p_acl_lim;
        w_acl |-> {1'b0, reg_wdata[5:0]} < {ratio_q, 1'b0};
    endproperty
    property p_acl_rd;
        reg_addr == 8'ha1 |-> reg_rdata[5:0] == acl_q;
    endproperty
    property p_ctl_rd;
        reg_addr == 8'ha2 |-> reg_rdata == ctl_q;
    endproperty
    property p_phase_seq;
        w_lo |=> w_hi;
    endproperty
    property p_phase_min;
        w_hi |-> phase_new >= 13'h012c;
    endproperty
    property p_hi_after_lo;
        w_hi |-> $past(w_lo);
    endproperty
    a_ratio_nz: assert property (p_ratio_nz) else $error("ratio of zero sent");
    a_ratio_rd: assert property (p_ratio_rd) else $error("ratio readback wrong");
    a_acl_lim: assert property (p_acl_lim) else $error("length not below twice ratio");
    a_acl_rd: assert property (p_acl_rd) else $error("length readback wrong");
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    a_phase_seq: assert property (p_phase_seq) else $error("phase high byte missing");
    a_phase_min: assert property (p_phase_min) else $error("phase below minimum");
    a_hi_after_lo: assert property (p_hi_after_lo) else $error("phase high without low");
    c_ratio: cover property (w_ratio);
    c_acl: cover property (w_acl);
    c_phase: cover property (w_lo ##1 w_hi);
endmodule
`default_nettype wire

// ### dv/test_horizontal_video_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module test_horizontal_video_prescaler;
    import hvp_pkg::*;
    logic        clk_sys_in, nrst_in, hwrite, hrdy, hresp, src_ready, src_sol, src_eol;
    logic        src_valid, dst_sol, dst_eol, dst_valid, dst_ready, stall, in_line;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [7:0]  cyc;
    hvp_pix_t    src_y, src_c, dst_y, dst_c, exp_y, exp_c;
    int          n_fail, total_checks, n_out, k, nexp;
    // ratio, length, control, phase per constant-line pass
    logic [31:0] cfg [5][4] = '{'{1, 0, 'h00, 1024}, '{2, 2, 'h5a, 342}, '{3, 3, 'ha2, 2048},
                                '{4, 7, 'hf3, 1500}, '{5, 8, 'hdc, 8191}};
    hvp_if i_hvp_if ();
    hvp_ctrl i_hvp_ctrl (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata), .link(i_hvp_if));
    hvp_scaler i_hvp_scaler (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .src_y_in(src_y), .src_c_in(src_c),
        .src_sol_in(src_sol), .src_eol_in(src_eol), .src_valid_in(src_valid), .src_ready_out(src_ready),
        .dst_y_out(dst_y), .dst_c_out(dst_c), .dst_sol_out(dst_sol), .dst_eol_out(dst_eol),
        .dst_valid_out(dst_valid), .dst_ready_in(dst_ready), .link(i_hvp_if));
    hvp_link_checker i_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_addr(i_hvp_if.reg_addr),
        .reg_wdata(i_hvp_if.reg_wdata), .reg_we(i_hvp_if.reg_we), .reg_rdata(i_hvp_if.reg_rdata));
    // ****************************************
    // reporting
    // ****************************************
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0h", $time, m, got);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 200) begin
            check(0, 1, "wait ran out");
            stop_test();
        end
    endtask
    // ****************************************
    // bus access, entered just after a rising edge
    // ****************************************
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        @(negedge clk_sys_in);
        for (k = 0; k < 200 && hrdy !== 1'b1; k++) @(negedge clk_sys_in);
        hang(k);
        @(posedge clk_sys_in);
        htrans <= 2'h0;
        hwdata <= d;
        @(negedge clk_sys_in);
        for (k = 0; k < 200 && hrdy !== 1'b1; k++) @(negedge clk_sys_in);
        hang(k);
        q = hrdata;
        check(hresp, 1'b0, "bus response");
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(q, exp, "register read");
    endtask
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            src_valid <= 1'b1;
            src_y     <= exp_y;
            src_c     <= exp_c;
            src_sol   <= i == 0;
            src_eol   <= i == n - 1;
            @(negedge clk_sys_in);
            for (k = 0; k < 200 && src_ready !== 1'b1; k++) @(negedge clk_sys_in);
            hang(k);
            @(posedge clk_sys_in);
        end
        src_valid <= 1'b0;
    endtask
    // ****************************************
    // sink with a periodic stall
    // ****************************************
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 8'h01;
        dst_ready <= !stall && cyc[1:0] != 2'h3;
        if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
            n_out++;
            check({dst_y, dst_c}, {exp_y, exp_c}, "pixel");
            check(dst_sol, !in_line, "line start flag");
            in_line = !dst_eol;
        end
    end
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        check(0, 1, "run too long");
        stop_test();
    end
    initial begin
        {nrst_in, hwrite, src_valid, src_sol, src_eol, stall, in_line} = 0;
        {htrans, haddr, hwdata, src_y, src_c, exp_y, exp_c, cyc, dst_ready} = 0;
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(32'h280, 32'h1);
        rd(32'h284, 32'h0);
        rd(32'h288, 32'h0);
        rd(32'h2a0, 32'h400);
        rd(32'h300, 32'h0);
        rd(32'h2ac, 32'h0);
        ahb(1'b1, 32'h280, 32'h0);
        rd(32'h280, 32'h1);
        ahb(1'b1, 32'h2a0, 32'd100);
        rd(32'h2a0, 32'h12c);
        ahb(1'b1, 32'h280, 32'h2);
        ahb(1'b1, 32'h284, 32'h3f);
        rd(32'h284, 32'h3);
        exp_y = 8'h64;
        exp_c = 8'hc8;
        for (int j = 0; j < 5; j++) begin
            ahb(1'b1, 32'h280, cfg[j][0]);
            ahb(1'b1, 32'h284, cfg[j][1]);
            ahb(1'b1, 32'h288, cfg[j][2]);
            ahb(1'b1, 32'h2a0, cfg[j][3]);
            rd(32'h288, cfg[j][2]);
            n_out = 0;
            stall = j == 1;
            fork
                send(40);
                begin
                    repeat (40) @(posedge clk_sys_in);
                    @(negedge clk_sys_in);
                    // a long stall must back up to the source, not drop data
                    if (j == 1) check({src_ready, dst_valid}, 2'b01, "backpressure");
                    stall = 0;
                end
            join
            for (k = 0; k < 200 && (in_line || dst_valid !== 1'b0); k++) @(negedge clk_sys_in);
            hang(k);
            nexp = 40 * 1024 / (cfg[j][0] * cfg[j][3]);
            check(n_out + 3 >= nexp && n_out <= nexp + 3, 1, "output count");
        end
        stop_test();
    end
endmodule
`default_nettype wire
